// ---- design/pcd_change_detect.sv ----
// pin-change event detection over the indexed pin-change sources
`timescale 1ns/1ns
`default_nettype none
module pcd_change_detect
  import pcd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  pcd_line_if.chg line
);
  logic [CHG_HI:CHG_C_BASE] prev;
  logic [CHG_HI:CHG_C_BASE] event_q;

  assign line.chg_event = event_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prev <= RST_CHG;
    end
    else
    begin
      prev <= line.chg_level;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      event_q <= RST_CHG;
    end
    else
    begin
      event_q <= (line.chg_level ^ prev) & line.chg_mask;
    end
  end

  a_change_event: assert property (@(posedge clk_in) disable iff (rst_in)
    (line.chg_mask[CHG_D_BASE] && line.chg_level[CHG_D_BASE] != prev[CHG_D_BASE]) |=> event_q[CHG_D_BASE])
    else $error("masked pin change gave no event");
  c_any_event: cover property (@(posedge clk_in) disable iff (rst_in) |event_q);
endmodule : pcd_change_detect
`default_nettype wire

// ---- design/pcd_port_override.sv ----
// alternate-function override of port c and port d pads
// Operation
// - with the two-wire enable set, port c bit 4 leaves port control and becomes the two-wire data line.
// - the two-wire input path drops glitches shorter than 50 ns before the interface sees them.
// - an owned two-wire line is open-drain: value 0, direction from the interface, pull-up port AND NOT disable.
// - two-wire enable turns on slew limiting for port c bits 5 and 4.
// - the two-wire inputs come from the raw analog-side pin path, filtered, not the gated digital input.
// - port c bits 4..0 are pin-change sources 12..8.
// - port c bits 5..0 override digital-input enable on mask AND group1 or adc disable, value mask AND group1.
// - port c bit 6 takes pull-up 1 and direction 0 under the reset-disable fuse, din override fuse OR source 14.
// - port d bits 7..0 are pin-change sources 23..16.
// - port d bit 5 carries timer1 count and timer0 compare b, bit 4 usart clock and timer0 count, bit 6 compare a.
// - port d bit 3 carries ext irq 1 and timer2 compare b, bit 2 ext irq 0, bit 1 usart tx, bit 0 usart rx.
// - timer0 compare a reaches port d bit 6 only when software set its direction; no direction is forced.
// - the timer0 compare a pin also carries the pwm waveform.
// - the global pull-up disable turns off every pull-up.
`timescale 1ns/1ns
`default_nettype none
module pcd_port_override
  import pcd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [pcd_pkg::PC_W-1:0] portc_pin_in,
  input wire logic [pcd_pkg::PC_W-1:0] portc_port_in,
  input wire logic [pcd_pkg::PC_W-1:0] portc_dir_in,
  input wire logic [pcd_pkg::PC_W-1:0] portc_change_mask_in,
  input wire logic [pcd_pkg::PC_ADC_W-1:0] adc_digital_in_disable_in,
  input wire logic [pcd_pkg::PD_W-1:0] portd_pin_in,
  input wire logic [pcd_pkg::PD_W-1:0] portd_port_in,
  input wire logic [pcd_pkg::PD_W-1:0] portd_dir_in,
  input wire logic [pcd_pkg::PD_W-1:0] portd_change_mask_in,
  input wire logic global_pullup_disable_in,
  input wire logic sleep_din_off_in,
  input wire logic pin_change_group1_enable_in,
  input wire logic pin_change_group2_enable_in,
  input wire logic reset_pin_disable_fuse_in,
  input wire logic two_wire_enable_in,
  input wire logic two_wire_sda_drive_in,
  input wire logic two_wire_scl_drive_in,
  input wire logic timer0_compare_a_out_in,
  input wire logic timer0_compare_a_enable_in,
  input wire logic timer0_pwm_mode_in,
  input wire logic timer0_compare_b_out_in,
  input wire logic timer0_compare_b_enable_in,
  input wire logic timer2_compare_b_out_in,
  input wire logic timer2_compare_b_enable_in,
  input wire logic usart_tx_enable_in,
  input wire logic usart_txd_in,
  input wire logic usart_rx_enable_in,
  input wire logic usart_clock_master_in,
  input wire logic usart_serial_clock_drive_in,
  input wire logic ext_irq_0_enable_in,
  input wire logic ext_irq_1_enable_in,
  output logic [pcd_pkg::PC_W-1:0] portc_pin_out,
  output logic [pcd_pkg::PC_W-1:0] portc_pin_oe_out,
  output logic [pcd_pkg::PC_W-1:0] portc_pull_out,
  output logic [pcd_pkg::PC_W-1:0] portc_slew_limit_out,
  output logic [pcd_pkg::PD_W-1:0] portd_pin_out,
  output logic [pcd_pkg::PD_W-1:0] portd_pin_oe_out,
  output logic [pcd_pkg::PD_W-1:0] portd_pull_out,
  output logic two_wire_sda_in_out,
  output logic two_wire_scl_in_out,
  output logic [pcd_pkg::CHG_HI:pcd_pkg::CHG_C_BASE] pin_change_src_out,
  output logic [pcd_pkg::CHG_HI:pcd_pkg::CHG_C_BASE] pin_change_event_out,
  output logic timer0_count_in_out,
  output logic timer1_count_in_out,
  output logic usart_serial_clock_in_out,
  output logic usart_rxd_out,
  output logic ext_irq_0_out,
  output logic ext_irq_1_out
);
  import pcd_pkg::*;

  pcd_line_if line ();

  pcd_ovr_t c_ovr [PC_W];
  pcd_ovr_t d_ovr [PD_W];
  pcd_pad_t c_pad [PC_W];
  pcd_pad_t d_pad [PD_W];
  logic [PC_W-1:0] c_din;
  logic [PD_W-1:0] d_din;
  logic [PC_W-1:0] next_c_din_en;
  logic [PD_W-1:0] next_d_din_en;

  // one pad resolution serves both ports; the pull-up disable is applied last so nothing escapes it
  function automatic pcd_pad_t pcd_resolve(input pcd_ovr_t o, input logic dir, input logic port,
                                           input logic pu_off, input logic sleep_off);
    pcd_pad_t r;
    r.pull = (o.pullup_override_enable ? o.pullup_override_value : (!dir && port)) && !pu_off;
    r.oe = o.direction_override_enable ? o.direction_override_value : dir;
    r.val = o.out_value_override_enable ? o.out_value_override_value : port;
    r.din_en = o.din_enable_override_enable ? o.din_enable_override_value : !sleep_off;
    return r;
  endfunction : pcd_resolve

  // port c override table
  always_comb
  begin
    for (int i = 0; i < PC_W; i++)
    begin
      c_ovr[i] = OVR_NONE;
    end
    for (int i = 0; i < PC_ADC_W; i++)
    begin
      c_ovr[i].din_enable_override_enable = (portc_change_mask_in[i] && pin_change_group1_enable_in)
                                            || adc_digital_in_disable_in[i];
      c_ovr[i].din_enable_override_value = portc_change_mask_in[i] && pin_change_group1_enable_in;
    end
    c_ovr[PC_SDA].pullup_override_enable = two_wire_enable_in;
    c_ovr[PC_SDA].pullup_override_value = portc_port_in[PC_SDA] && !global_pullup_disable_in;
    c_ovr[PC_SDA].direction_override_enable = two_wire_enable_in;
    c_ovr[PC_SDA].direction_override_value = two_wire_sda_drive_in;
    c_ovr[PC_SDA].out_value_override_enable = two_wire_enable_in;
    c_ovr[PC_SDA].out_value_override_value = 1'b0;
    c_ovr[PC_SCL].pullup_override_enable = two_wire_enable_in;
    c_ovr[PC_SCL].pullup_override_value = portc_port_in[PC_SCL] && !global_pullup_disable_in;
    c_ovr[PC_SCL].direction_override_enable = two_wire_enable_in;
    c_ovr[PC_SCL].direction_override_value = two_wire_scl_drive_in;
    c_ovr[PC_SCL].out_value_override_enable = two_wire_enable_in;
    c_ovr[PC_SCL].out_value_override_value = 1'b0;
    c_ovr[PC_RST].pullup_override_enable = reset_pin_disable_fuse_in;
    c_ovr[PC_RST].pullup_override_value = 1'b1;
    c_ovr[PC_RST].direction_override_enable = reset_pin_disable_fuse_in;
    c_ovr[PC_RST].direction_override_value = 1'b0;
    c_ovr[PC_RST].din_enable_override_enable = reset_pin_disable_fuse_in
                                               || (portc_change_mask_in[PC_RST] && pin_change_group1_enable_in);
    c_ovr[PC_RST].din_enable_override_value = reset_pin_disable_fuse_in;
  end

  // port d override table
  always_comb
  begin
    for (int i = 0; i < PD_W; i++)
    begin
      d_ovr[i] = OVR_NONE;
      d_ovr[i].din_enable_override_enable = portd_change_mask_in[i] && pin_change_group2_enable_in;
      d_ovr[i].din_enable_override_value = 1'b1;
    end
    // compare a never touches direction: software must set it
    d_ovr[PD_COMPARE_A].out_value_override_enable = timer0_compare_a_enable_in
                                                    || timer0_pwm_mode_in;
    d_ovr[PD_COMPARE_A].out_value_override_value = timer0_compare_a_out_in;
    d_ovr[PD_TIMER1_COUNT].out_value_override_enable = timer0_compare_b_enable_in;
    d_ovr[PD_TIMER1_COUNT].out_value_override_value = timer0_compare_b_out_in;
    d_ovr[PD_SERIAL_CLOCK].out_value_override_enable = usart_clock_master_in;
    d_ovr[PD_SERIAL_CLOCK].out_value_override_value = usart_serial_clock_drive_in;
    d_ovr[PD_IRQ1].out_value_override_enable = timer2_compare_b_enable_in;
    d_ovr[PD_IRQ1].out_value_override_value = timer2_compare_b_out_in;
    d_ovr[PD_IRQ1].din_enable_override_enable = ext_irq_1_enable_in
                                                || d_ovr[PD_IRQ1].din_enable_override_enable;
    d_ovr[PD_IRQ0].din_enable_override_enable = ext_irq_0_enable_in
                                                || d_ovr[PD_IRQ0].din_enable_override_enable;
    d_ovr[PD_TXD].pullup_override_enable = usart_tx_enable_in;
    d_ovr[PD_TXD].direction_override_enable = usart_tx_enable_in;
    d_ovr[PD_TXD].direction_override_value = 1'b1;
    d_ovr[PD_TXD].out_value_override_enable = usart_tx_enable_in;
    d_ovr[PD_TXD].out_value_override_value = usart_txd_in;
    // receiver forces input but leaves the pull-up under port control
    d_ovr[PD_RXD].pullup_override_enable = usart_rx_enable_in;
    d_ovr[PD_RXD].pullup_override_value = portd_port_in[PD_RXD] && !global_pullup_disable_in;
    d_ovr[PD_RXD].direction_override_enable = usart_rx_enable_in;
    d_ovr[PD_RXD].direction_override_value = 1'b0;
  end

  genvar g;
  generate
    for (g = 0; g < PC_W; g++)
    begin : g_pc
      assign c_pad[g] = pcd_resolve(c_ovr[g], portc_dir_in[g], portc_port_in[g],
                                    global_pullup_disable_in, sleep_din_off_in);
      assign next_c_din_en[g] = c_pad[g].din_en;
    end
    for (g = 0; g < PD_W; g++)
    begin : g_pd
      assign d_pad[g] = pcd_resolve(d_ovr[g], portd_dir_in[g], portd_port_in[g],
                                    global_pullup_disable_in, sleep_din_off_in);
      assign next_d_din_en[g] = d_pad[g].din_en;
    end
  endgenerate

  // pad drive registers
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      portc_pin_out <= RST_PC;
      portc_pin_oe_out <= RST_PC;
      portc_pull_out <= RST_PC;
      portd_pin_out <= RST_PD;
      portd_pin_oe_out <= RST_PD;
      portd_pull_out <= RST_PD;
    end
    else
    begin
      for (int i = 0; i < PC_W; i++)
      begin
        portc_pin_out[i] <= c_pad[i].val;
        portc_pin_oe_out[i] <= c_pad[i].oe;
        portc_pull_out[i] <= c_pad[i].pull;
      end
      for (int i = 0; i < PD_W; i++)
      begin
        portd_pin_out[i] <= d_pad[i].val;
        portd_pin_oe_out[i] <= d_pad[i].oe;
        portd_pull_out[i] <= d_pad[i].pull;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      portc_slew_limit_out <= RST_PC;
    end
    else
    begin
      portc_slew_limit_out <= RST_PC;
      portc_slew_limit_out[PC_SDA] <= two_wire_enable_in;
      portc_slew_limit_out[PC_SCL] <= two_wire_enable_in;
    end
  end

  // digital input capture; a disabled input reads low
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      c_din <= RST_PC;
      d_din <= RST_PD;
    end
    else
    begin
      c_din <= portc_pin_in & next_c_din_en;
      d_din <= portd_pin_in & next_d_din_en;
    end
  end

  // the filters see the ungated pin, so adc disable never blinds the two-wire logic
  assign line.tw_raw[TW_SDA] = portc_pin_in[PC_SDA];
  assign line.tw_raw[TW_SCL] = portc_pin_in[PC_SCL];
  assign line.chg_level = {d_din, 1'b0, c_din};
  assign line.chg_mask = {portd_change_mask_in & {PD_W{pin_change_group2_enable_in}}, 1'b0,
                          portc_change_mask_in & {PC_W{pin_change_group1_enable_in}}};

  pcd_spike_filter u_filter (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .line (line.filt)
  );

  pcd_change_detect u_change (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .line (line.chg)
  );

  assign two_wire_sda_in_out = line.tw_clean[TW_SDA];
  assign two_wire_scl_in_out = line.tw_clean[TW_SCL];
  assign pin_change_src_out = line.chg_level;
  assign pin_change_event_out = line.chg_event;
  assign timer0_count_in_out = d_din[PD_SERIAL_CLOCK];
  assign usart_serial_clock_in_out = d_din[PD_SERIAL_CLOCK];
  assign timer1_count_in_out = d_din[PD_TIMER1_COUNT];
  assign ext_irq_1_out = d_din[PD_IRQ1];
  assign ext_irq_0_out = d_din[PD_IRQ0];
  assign usart_rxd_out = d_din[PD_RXD];

  a_sda_open_drain: assert property (@(posedge clk_in) disable iff (rst_in)
    two_wire_enable_in |=> !portc_pin_out[PC_SDA] && portc_pin_oe_out[PC_SDA] == $past(two_wire_sda_drive_in))
    else $error("two-wire data line not open drain");
  a_slew_follow: assert property (@(posedge clk_in) disable iff (rst_in)
    two_wire_enable_in |=> portc_slew_limit_out[PC_SDA] && portc_slew_limit_out[PC_SCL])
    else $error("slew limit missing with two-wire enabled");
  a_global_pull_off: assert property (@(posedge clk_in) disable iff (rst_in)
    global_pullup_disable_in |=> portc_pull_out == RST_PC && portd_pull_out == RST_PD)
    else $error("pull-up on while globally disabled");
  a_reset_pin_fuse: assert property (@(posedge clk_in) disable iff (rst_in)
    reset_pin_disable_fuse_in && !global_pullup_disable_in |=> portc_pull_out[PC_RST] && !portc_pin_oe_out[PC_RST])
    else $error("fused reset pin not input with pull-up");
  a_low_no_override: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> portc_pin_oe_out[PC_LOW_HI:0] == $past(portc_dir_in[PC_LOW_HI:0])
      && portc_pin_out[PC_LOW_HI:0] == $past(portc_port_in[PC_LOW_HI:0]))
    else $error("low port c bits overridden");
  a_adc_din_off: assert property (@(posedge clk_in) disable iff (rst_in)
    adc_digital_in_disable_in[0] && !(portc_change_mask_in[0] && pin_change_group1_enable_in)
      |=> !pin_change_src_out[CHG_C_BASE])
    else $error("adc-disabled input still reads high");
  a_compare_no_dir: assert property (@(posedge clk_in) disable iff (rst_in)
    !portd_dir_in[PD_COMPARE_A] |=> !portd_pin_oe_out[PD_COMPARE_A])
    else $error("compare a pin driven without direction");
  a_compare_pwm_out: assert property (@(posedge clk_in) disable iff (rst_in)
    timer0_pwm_mode_in |=> portd_pin_out[PD_COMPARE_A] == $past(timer0_compare_a_out_in))
    else $error("pwm waveform not on compare a pin");
  a_tx_drive: assert property (@(posedge clk_in) disable iff (rst_in)
    usart_tx_enable_in |=> portd_pin_oe_out[PD_TXD] && portd_pin_out[PD_TXD] == $past(usart_txd_in))
    else $error("usart tx pin not driven");
  c_two_wire_low: cover property (@(posedge clk_in) disable iff (rst_in)
    two_wire_enable_in && two_wire_sda_drive_in ##1 portc_pin_oe_out[PC_SDA]);
  c_pull_off_set: cover property (@(posedge clk_in) disable iff (rst_in)
    global_pullup_disable_in ##1 !global_pullup_disable_in);
  c_tx_on: cover property (@(posedge clk_in) disable iff (rst_in) usart_tx_enable_in && usart_rx_enable_in);
endmodule : pcd_port_override
`default_nettype wire

// ---- design/pcd_spike_filter.sv ----
// spike filters between the analog-side pin path and the two-wire logic
`timescale 1ns/1ns
`default_nettype none
module pcd_spike_filter
  import pcd_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  pcd_line_if.filt line
);
  logic [SPIKE_CNT_W-1:0] cnt [TW_LINES];
  logic [TW_LINES-1:0] clean;

  assign line.tw_clean = clean;

  genvar g;
  generate
    for (g = 0; g < TW_LINES; g++)
    begin : g_line
      // a new level is taken only after it has held for the full spike time
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          cnt[g] <= SPIKE_CNT_RST;
          clean[g] <= TW_IDLE;
        end
        else if (line.tw_raw[g] == clean[g])
        begin
          cnt[g] <= SPIKE_CNT_RST;
        end
        else if (cnt[g] == SPIKE_LAST)
        begin
          cnt[g] <= SPIKE_CNT_RST;
          clean[g] <= line.tw_raw[g];
        end
        else
        begin
          cnt[g] <= cnt[g] + 1'b1;
        end
      end

      a_spike_held: assert property (@(posedge clk_in) disable iff (rst_in)
        $changed(clean[g]) |-> $past(line.tw_raw[g], 1) == clean[g] && $past(line.tw_raw[g], 2) == clean[g]
          && $past(line.tw_raw[g], 3) == clean[g])
        else $error("two-wire line changed after a short spike");
    end
  endgenerate
endmodule : pcd_spike_filter
`default_nettype wire

// ---- inc/pcd_line_if.sv ----
// internal carrier between the override core, spike filters and change detector
`timescale 1ns/1ns
`default_nettype none
interface pcd_line_if;
  import pcd_pkg::*;
  logic [TW_LINES-1:0] tw_raw;
  logic [TW_LINES-1:0] tw_clean;
  logic [CHG_HI:CHG_C_BASE] chg_level;
  logic [CHG_HI:CHG_C_BASE] chg_mask;
  logic [CHG_HI:CHG_C_BASE] chg_event;
  modport filt (input tw_raw, output tw_clean);
  modport chg (input chg_level, input chg_mask, output chg_event);
  modport top (output tw_raw, output chg_level, output chg_mask, input tw_clean, input chg_event);
endinterface : pcd_line_if
`default_nettype wire

// ---- inc/pcd_pkg.sv ----
// constants and types shared by the port c/d override logic
package pcd_pkg;
  localparam int PC_W = 7;
  localparam int PD_W = 8;
  localparam int PC_ADC_W = 6;
  localparam int PC_SDA = 4;
  localparam int PC_SCL = 5;
  localparam int PC_RST = 6;
  localparam int PC_LOW_HI = 3;
  localparam int PD_RXD = 0;
  localparam int PD_TXD = 1;
  localparam int PD_IRQ0 = 2;
  localparam int PD_IRQ1 = 3;
  localparam int PD_SERIAL_CLOCK = 4;
  localparam int PD_TIMER1_COUNT = 5;
  localparam int PD_COMPARE_A = 6;
  localparam int CHG_C_BASE = 8;
  localparam int CHG_D_BASE = 16;
  localparam int CHG_HI = 23;
  localparam int CHG_GAP = 15;
  localparam int TW_LINES = 2;
  localparam int TW_SDA = 0;
  localparam int TW_SCL = 1;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SPIKE_CNT_W = $clog2(SPIKE_CYC + 1);
  localparam logic [SPIKE_CNT_W-1:0] SPIKE_LAST = SPIKE_CNT_W'(SPIKE_CYC - 1);
  localparam logic [SPIKE_CNT_W-1:0] SPIKE_CNT_RST = '0;
  localparam logic TW_IDLE = 1'b1;
  localparam logic [PC_W-1:0] RST_PC = 7'h00;
  localparam logic [PD_W-1:0] RST_PD = 8'h00;
  localparam logic [CHG_HI:CHG_C_BASE] RST_CHG = 16'h0000;

  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic out_value_override_enable;
    logic out_value_override_value;
    logic din_enable_override_enable;
    logic din_enable_override_value;
  } pcd_ovr_t;

  typedef struct packed {
    logic pull;
    logic oe;
    logic val;
    logic din_en;
  } pcd_pad_t;

  localparam pcd_ovr_t OVR_NONE = '0;
endpackage : pcd_pkg

// ---- tb/pcd_pad_model.sv ----
// far-side pad model: outside drivers meeting the block's pad drivers
`timescale 1ns/1ns
`default_nettype none
module pcd_pad_model #(parameter int W = 8)
(
  input wire logic [W-1:0] oe_in,
  input wire logic [W-1:0] val_in,
  input wire logic [W-1:0] ext_in,
  output logic [W-1:0] pin_out
);
  // the block wins where it drives; an open-drain low is simply a driven zero
  assign pin_out = (oe_in & val_in) | (~oe_in & ext_in);
endmodule : pcd_pad_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the port c/d override logic
`timescale 1ns/1ns
`default_nettype none
module tb;
  import pcd_pkg::*;
  typedef struct {int k; logic [31:0] e;} pcd_note_t;
  logic clk_in = 0, rst_in = 1, gpd = 0, slp = 0, g1 = 0, g2 = 0, fuse = 0, tw = 0, sdd = 0, scd = 0;
  logic ta = 0, tae = 0, pwm = 0, tbo = 0, tbe = 0, t2 = 0, t2e = 0, txe = 0, txd = 0, rxe = 0, xm = 0, xd = 0;
  logic e0 = 0, e1 = 0, sda, scl, t0c, t1c, xin, rxd, i0, i1;
  logic [PC_W-1:0] cpo = 0, cdi = 0, cmk = 0, cex = 0, cpi, cv, co, cp, cs;
  logic [PC_ADC_W-1:0] adc = 0;
  logic [PD_W-1:0] dpo = 0, ddi = 0, dmk = 0, dex = 0, dpi, dv, dq, dp;
  logic [CHG_HI:CHG_C_BASE] src, evt;
  pcd_note_t q[$];
  int failures = 0, comparisons = 0, seed = 31;
  event go;

  initial forever #10 clk_in = ~clk_in;

  pcd_port_override dut (.clk_in(clk_in), .rst_in(rst_in), .portc_pin_in(cpi), .portc_port_in(cpo),
    .portc_dir_in(cdi), .portc_change_mask_in(cmk), .adc_digital_in_disable_in(adc), .portd_pin_in(dpi),
    .portd_port_in(dpo), .portd_dir_in(ddi), .portd_change_mask_in(dmk), .global_pullup_disable_in(gpd),
    .sleep_din_off_in(slp), .pin_change_group1_enable_in(g1), .pin_change_group2_enable_in(g2),
    .reset_pin_disable_fuse_in(fuse), .two_wire_enable_in(tw), .two_wire_sda_drive_in(sdd),
    .two_wire_scl_drive_in(scd), .timer0_compare_a_out_in(ta), .timer0_compare_a_enable_in(tae),
    .timer0_pwm_mode_in(pwm), .timer0_compare_b_out_in(tbo), .timer0_compare_b_enable_in(tbe),
    .timer2_compare_b_out_in(t2), .timer2_compare_b_enable_in(t2e), .usart_tx_enable_in(txe),
    .usart_txd_in(txd), .usart_rx_enable_in(rxe), .usart_clock_master_in(xm), .usart_serial_clock_drive_in(xd),
    .ext_irq_0_enable_in(e0), .ext_irq_1_enable_in(e1), .portc_pin_out(cv), .portc_pin_oe_out(co),
    .portc_pull_out(cp), .portc_slew_limit_out(cs), .portd_pin_out(dv), .portd_pin_oe_out(dq),
    .portd_pull_out(dp), .two_wire_sda_in_out(sda), .two_wire_scl_in_out(scl), .pin_change_src_out(src),
    .pin_change_event_out(evt), .timer0_count_in_out(t0c), .timer1_count_in_out(t1c),
    .usart_serial_clock_in_out(xin), .usart_rxd_out(rxd), .ext_irq_0_out(i0), .ext_irq_1_out(i1));
  pcd_pad_model #(.W(PC_W)) pad_c (.oe_in(co), .val_in(cv), .ext_in(cex), .pin_out(cpi));
  pcd_pad_model #(.W(PD_W)) pad_d (.oe_in(dq), .val_in(dv), .ext_in(dex), .pin_out(dpi));

  function automatic logic [31:0] got(input int k);
    case (k)
      0: return 32'(cv);
      1: return 32'(co);
      2: return 32'(cp);
      3: return 32'(cs);
      4: return 32'(dv);
      5: return 32'(dq);
      6: return 32'(dp);
      7: return 32'(src);
      8: return 32'(evt);
      9: return {30'h0, scl, sda};
      default: return {26'h0, t0c, xin, t1c, i1, i0, rxd};
    endcase
  endfunction : got

  task automatic note(input int k, input logic [31:0] e);
    q.push_back('{k, e});
  endtask : note

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask : step

  task automatic report(input int k, input logic [31:0] e);
    failures++;
    $display("[FAIL] t=%0t kind=%0d exp=%h got=%h", $time, k, e, got(k));
  endtask : report

  task automatic cmp_pad(input int k, input logic [31:0] e);
    comparisons++;
    if (got(k) !== e) report(k, e);
  endtask : cmp_pad

  task automatic cmp_in(input int k, input logic [31:0] e);
    comparisons++;
    if (got(k) !== e) report(k, e);
  endtask : cmp_in

  task automatic test_done();
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // expected pads, sources and derived inputs for inputs held steady
  task automatic expect_all();
    logic [PC_W-1:0] a, b, u, mg, ov, vv, pc;
    logic [PD_W-1:0] f, h, w, od, pd;
    logic [15:0] s;
    a = cpo;
    b = cdi;
    u = cpo & ~cdi;
    b[6] = fuse ? 1'b0 : b[6];
    u[6] = fuse | u[6];
    a[5:4] = tw ? 2'b00 : a[5:4];
    b[5:4] = tw ? {scd, sdd} : b[5:4];
    u[5:4] = tw ? cpo[5:4] : u[5:4];
    f = dpo;
    h = ddi;
    w = dpo & ~ddi;
    f[6] = (tae | pwm) ? ta : f[6];
    f[5] = tbe ? tbo : f[5];
    f[4] = xm ? xd : f[4];
    f[3] = t2e ? t2 : f[3];
    f[1] = txe ? txd : f[1];
    h[1] = txe | h[1];
    w[1] = txe ? 1'b0 : w[1];
    h[0] = rxe ? 1'b0 : h[0];
    w[0] = rxe ? dpo[0] : w[0];
    note(0, 32'(a));
    note(1, 32'(b));
    note(2, 32'(u & ~{PC_W{gpd}}));
    note(3, tw ? 32'h30 : 32'h0);
    note(4, 32'(f));
    note(5, 32'(h));
    note(6, 32'(w & ~{PD_W{gpd}}));
    pc = (b & a) | (~b & cex);
    pd = (h & f) | (~h & dex);
    mg = cmk & {PC_W{g1}};
    ov = {fuse | mg[6], mg[5:0] | adc};
    vv = {fuse, mg[5:0]};
    od = (dmk & {PD_W{g2}}) | {4'h0, e1, e0, 2'h0};
    s = {pd & (od | {PD_W{~slp}}), 1'b0, pc & ((ov & vv) | (~ov & {PC_W{~slp}}))};
    note(7, 32'(s));
    note(10, {26'h0, s[12], s[12], s[13], s[11], s[10], s[8]});
    if (tw) note(9, {30'h0, pc[5], pc[4]});
    note(8, 32'h0);
    -> go;
  endtask : expect_all

  initial
  begin
    pcd_note_t n;
    forever
    begin
      @(go);
      while (q.size() > 0)
      begin
        n = q.pop_front();
        if (n.k < 7)
          cmp_pad(n.k, n.e);
        else
          cmp_in(n.k, n.e);
      end
    end
  end

  initial
  begin
    logic [95:0] r;
    step(5);
    note(1, 32'h0);
    note(7, 32'h0);
    note(9, 32'h3);
    -> go;
    step(5);
    rst_in = 0;
    repeat (40)
    begin
      r = {$random(seed), $random(seed), $random(seed)};
      {cpo, cdi, cmk, cex, adc} = r[33:0];
      {dpo, ddi, dmk, dex} = r[65:34];
      {gpd, slp, g1, g2, fuse, tw, sdd, scd, ta, tae, pwm} = r[76:66];
      {tbo, tbe, t2, t2e, txe, txd, rxe, xm, xd, e0, e1} = r[87:77];
      // comparator pins left as plain inputs without pull-up half the time
      if (r[88]) {ddi[7:6], dpo[7:6]} = 4'h0;
      step(5);
      expect_all();
    end
    // glitch shorter than the filter span must not reach the two-wire side
    {tw, sdd, scd, slp} = 4'b1001;
    adc = 6'h3f;
    cex = 7'h7f;
    cdi = 7'h00;
    step(6);
    cex[4] = 1'b0;
    step(2);
    cex[4] = 1'b1;
    repeat (6)
    begin
      step(1);
      note(9, 32'h3);
      -> go;
    end
    cex[4] = 1'b0;
    step(2);
    note(9, 32'h3);
    -> go;
    step(1);
    note(9, 32'h2);
    -> go;
    // walk every change source and check its one-cycle event
    {tw, slp, g1, g2, fuse, e0, e1, txe, rxe} = 9'b001110000;
    {cdi, ddi, cmk, dmk, adc} = {15'h0, 15'h7fff, 6'h0};
    step(4);
    for (int j = 0; j < 16; j++)
    begin
      if (j == 7) continue;
      if (j < 7)
        cex[j] = ~cex[j];
      else
        dex[j-8] = ~dex[j-8];
      step(2);
      note(8, 32'(1) << j);
      -> go;
      step(1);
      note(8, 32'h0);
      -> go;
    end
    g2 = 1'b0;
    dex[0] = ~dex[0];
    step(2);
    note(8, 32'h0);
    -> go;
    step(2);
    test_done();
  end
endmodule : tb
`default_nettype wire
